// *** include/bld_pkg.sv ***
// Shared constants for the backlight level, dim and off control block.
package bld_pkg;

  // ---------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_MODE     = 8'h00;
  localparam logic [7:0] ADDR_CONFIG   = 8'h02;
  localparam logic [7:0] ADDR_DELAYS   = 8'h03;
  localparam logic [7:0] ADDR_L1_MAX   = 8'h05;
  localparam logic [7:0] ADDR_L1_LOW   = 8'h06;
  localparam logic [7:0] ADDR_L2_MAX   = 8'h07;
  localparam logic [7:0] ADDR_L2_LOW   = 8'h08;
  localparam logic [7:0] ADDR_L3_MAX   = 8'h09;
  localparam logic [7:0] ADDR_L3_LOW   = 8'h0A;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int BIT_BACKLIGHT_ON   = 0;
  localparam int BIT_DIM_REQUEST    = 1;
  localparam int BIT_OPERATE        = 5;
  localparam int BIT_AUTO_ADJUST    = 0;
  localparam int BIT_KEY_WAKE       = 1;
  localparam int POS_CURVE          = 2;
  localparam int POS_LEVEL          = 4;
  localparam int POS_DIM_DELAY      = 0;
  localparam int POS_OFF_DELAY      = 4;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] RST_MODE   = 8'h00;
  localparam logic [7:0] RST_CONFIG = 8'h00;
  localparam logic [7:0] RST_DELAYS = 8'h00;
  localparam logic [6:0] RST_CODE   = 7'h00;

  // ---------------------------------------------------------------
  // Encodings and scaling
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    LVL_DAYLIGHT = 2'b00,
    LVL_OFFICE   = 2'b01,
    LVL_DARK     = 2'b10,
    LVL_DARK_ALT = 2'b11
  } bld_level_e;

  localparam logic [1:0]  CURVE_LINEAR = 2'b00;
  localparam logic [1:0]  CURVE_SQUARE = 2'b01;
  localparam logic [13:0] CODE_FULL    = 14'h007F;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLOCK_MHZ       = 125;
  localparam int TIMEBASE_MS     = 1000;
  localparam int TIMEBASE_CYCLES = TIMEBASE_MS * 1000 * CLOCK_MHZ;

  // Delay in seconds for each setting; setting zero leaves the countdown off.
  localparam logic [6:0] DELAY_SEC [16] = '{
    7'h00, 7'h0A, 7'h0F, 7'h14, 7'h19, 7'h1E, 7'h23, 7'h28,
    7'h2D, 7'h32, 7'h37, 7'h3C, 7'h46, 7'h50, 7'h64, 7'h78
  };

endpackage : bld_pkg

// *** core/bld_delay_timer.sv ***
// Seconds countdown used for the automatic dim and off delays.
`timescale 1ns/10ps
`default_nettype none

module bld_delay_timer
  import bld_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       rst,
  input  wire logic       tick,
  input  wire logic       restart,
  input  wire logic       run,
  input  wire logic [3:0] setting,
  output logic            expired
);

  logic [6:0] remain;
  logic       armed;

  wire        last_second = (remain == 7'h01);
  wire [6:0]  load_value  = DELAY_SEC[setting];

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      remain  <= 7'h00;
      armed   <= 1'b0;
      expired <= 1'b0;
    end
    else
    begin
      expired <= 1'b0;
      if (restart)
      begin
        remain <= load_value;
        armed  <= (setting != 4'h0);
      end
      else if (!run)
        armed <= 1'b0;
      else if (armed && tick)
      begin
        remain <= remain - 7'h01;
        if (last_second)
        begin
          armed   <= 1'b0;
          expired <= 1'b1;
        end
      end
    end
  end

endmodule : bld_delay_timer
`default_nettype wire

// *** core/bld_backlight.sv ***
// Backlight level selection, brightness law, dim and off control.
`timescale 1ns/10ps
`default_nettype none

// How it works
// - Two-bit level field picks daylight, office, dark.
// - Daylight uses registers 0x05 max, 0x06 dim.
// - Office uses registers 0x07 max, 0x08 dim.
// - Dark uses registers 0x09 max, 0x0A dim.
// - Brightness codes are seven bits, 128 steps.
// - Linear law: drive equals code times 127.
// - Square law: drive equals code squared.
// - Operating and on bit lights the backlight.
// - Dim request selects dim code, clear restores max.
// - Keypad press sets the on bit when enabled.
// - Dim delay field offers fifteen durations.
// - Turn-on starts dim countdown; expiry sets dim.
// - Dim clear or re-on with dim bit 0 restores max, restarts.
// - Off delay field offers fifteen durations.
// - Off countdown expiry clears the on bit.
// - Rewriting on restarts the off countdown.
// - Clearing on bit turns backlight off immediately.
// - Both delays give max, then dim, then off if off delay is longer.
// - Automatic mode copies sensor level into field.
module bld_backlight
  import bld_pkg::*;
#(
  parameter int TICK_CYCLES = TIMEBASE_CYCLES
)
(
  input  wire logic       clock,
  input  wire logic       rst,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_write,
  input  wire logic       reg_read,
  output logic      [7:0] reg_rdata,
  input  wire logic       key_press_pin,
  input  wire logic       keypad_mode,
  input  wire logic [1:0] ambient_level_in,
  output logic      [6:0] sink_code,
  output logic     [13:0] sink_drive,
  output logic            backlight_lit
);

  // ---------------------------------------------------------------
  // Register storage
  // ---------------------------------------------------------------
  logic       backlight_on;
  logic       dim_request;
  logic       operate_not_standby;
  logic       auto_adjust;
  logic       key_wake_light;
  logic [1:0] brightness_curve_select;
  logic [1:0] ambient_level_select;
  logic [3:0] dim_delay_setting;
  logic [3:0] off_delay_setting;
  logic [6:0] level_code [6];

  // ---------------------------------------------------------------
  // Address decode
  // ---------------------------------------------------------------
  wire wr_mode   = reg_write && (reg_addr == ADDR_MODE);
  wire wr_config = reg_write && (reg_addr == ADDR_CONFIG);
  wire wr_delays = reg_write && (reg_addr == ADDR_DELAYS);

  wire wdata_on  = reg_wdata[BIT_BACKLIGHT_ON];
  wire wdata_dim = reg_wdata[BIT_DIM_REQUEST];

  // A write of one to the on bit counts as a re-assertion even if it was already set.
  wire bl_reassert  = wr_mode && wdata_on;
  wire host_dim_clr = wr_mode && !wdata_dim && dim_request;

  // ---------------------------------------------------------------
  // Key wake input
  // ---------------------------------------------------------------
  logic key_meta;
  logic key_sync;
  logic key_prev;

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      key_meta <= 1'b0;
      key_sync <= 1'b0;
      key_prev <= 1'b0;
    end
    else
    begin
      key_meta <= key_press_pin;
      key_sync <= key_meta;
      key_prev <= key_sync;
    end
  end

  wire key_rise = key_sync && !key_prev;
  wire key_wake = key_rise && keypad_mode && key_wake_light;

  // ---------------------------------------------------------------
  // Timebase and countdowns
  // ---------------------------------------------------------------
  localparam int TW = $clog2(TICK_CYCLES + 1);

  logic [TW-1:0] tick_count;
  logic          tick;
  logic          dim_expire;
  logic          off_expire;

  wire tick_wrap = (tick_count == TW'(TICK_CYCLES - 1));

  // Free-running divider so that a long delay needs only a seconds counter.
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      tick_count <= '0;
      tick       <= 1'b0;
    end
    else
    begin
      tick_count <= tick_wrap ? '0 : tick_count + TW'(1);
      tick       <= tick_wrap;
    end
  end

  assign backlight_lit = operate_not_standby && backlight_on;

  wire restart_both = bl_reassert || key_wake;
  wire restart_dim  = restart_both || host_dim_clr;
  wire dim_run      = backlight_lit && !dim_request;

  bld_delay_timer u_dim_timer
  (
    .clock   (clock),
    .rst     (rst),
    .tick    (tick),
    .restart (restart_dim),
    .run     (dim_run),
    .setting (dim_delay_setting),
    .expired (dim_expire)
  );

  bld_delay_timer u_off_timer
  (
    .clock   (clock),
    .rst     (rst),
    .tick    (tick),
    .restart (restart_both),
    .run     (backlight_lit),
    .setting (off_delay_setting),
    .expired (off_expire)
  );

  // ---------------------------------------------------------------
  // Control bits
  // ---------------------------------------------------------------
  logic next_backlight_on;
  logic next_dim_request;

  // Hardware sets win over a clear arriving in the same cycle.
  always_comb
  begin
    next_backlight_on = backlight_on;
    if (wr_mode)
      next_backlight_on = wdata_on;
    else if (off_expire)
      next_backlight_on = 1'b0;
    if (key_wake)
      next_backlight_on = 1'b1;
  end

  // A written dim bit is honoured even on a re-assert, so the host can dim a lit backlight.
  always_comb
  begin
    next_dim_request = dim_request;
    if (wr_mode)
      next_dim_request = wdata_dim;
    if (key_wake)
      next_dim_request = 1'b0;
    if (dim_expire && !restart_dim)
      next_dim_request = 1'b1;
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      backlight_on        <= RST_MODE[BIT_BACKLIGHT_ON];
      dim_request         <= RST_MODE[BIT_DIM_REQUEST];
      operate_not_standby <= RST_MODE[BIT_OPERATE];
    end
    else
    begin
      backlight_on <= next_backlight_on;
      dim_request  <= next_dim_request;
      if (wr_mode)
        operate_not_standby <= reg_wdata[BIT_OPERATE];
    end
  end

  // ---------------------------------------------------------------
  // Configuration and codes
  // ---------------------------------------------------------------
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      auto_adjust             <= RST_CONFIG[BIT_AUTO_ADJUST];
      key_wake_light          <= RST_CONFIG[BIT_KEY_WAKE];
      brightness_curve_select <= RST_CONFIG[POS_CURVE +: 2];
      ambient_level_select    <= RST_CONFIG[POS_LEVEL +: 2];
      dim_delay_setting       <= RST_DELAYS[POS_DIM_DELAY +: 4];
      off_delay_setting       <= RST_DELAYS[POS_OFF_DELAY +: 4];
    end
    else
    begin
      if (wr_config)
      begin
        auto_adjust             <= reg_wdata[BIT_AUTO_ADJUST];
        key_wake_light          <= reg_wdata[BIT_KEY_WAKE];
        brightness_curve_select <= reg_wdata[POS_CURVE +: 2];
      end
      if (auto_adjust)
        ambient_level_select <= ambient_level_in;
      else if (wr_config)
        ambient_level_select <= reg_wdata[POS_LEVEL +: 2];
      if (wr_delays)
      begin
        dim_delay_setting <= reg_wdata[POS_DIM_DELAY +: 4];
        off_delay_setting <= reg_wdata[POS_OFF_DELAY +: 4];
      end
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < 6; gi++)
    begin : g_code
      wire hit = reg_write && (reg_addr == (ADDR_L1_MAX + 8'(gi)));
      always_ff @(posedge clock or posedge rst)
      begin
        if (rst)
          level_code[gi] <= RST_CODE;
        else if (hit)
          level_code[gi] <= reg_wdata[6:0];
      end
    end
  endgenerate

  // ---------------------------------------------------------------
  // Level and brightness selection
  // ---------------------------------------------------------------
  wire [1:0] eff_level = (ambient_level_select == LVL_DARK_ALT) ? LVL_DARK : ambient_level_select;
  wire [2:0] max_index = {eff_level, 1'b0};
  wire [2:0] low_index = {eff_level, 1'b1};
  wire [6:0] sel_max   = level_code[max_index];
  wire [6:0] sel_low   = level_code[low_index];

  // A dim code above the max code is passed through untouched.
  wire [6:0]  next_code   = !backlight_lit ? 7'h00 : (dim_request ? sel_low : sel_max);
  wire [13:0] code_wide   = {7'h00, next_code};
  wire [13:0] drive_lin   = 14'(code_wide * CODE_FULL);
  wire [13:0] drive_sq    = 14'(code_wide * code_wide);
  // The two other curve settings, 2 and 3, also take the square-law drive.
  wire [13:0] next_drive  = (brightness_curve_select == CURVE_LINEAR) ? drive_lin : drive_sq;

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      sink_code  <= 7'h00;
      sink_drive <= 14'h0000;
    end
    else
    begin
      sink_code  <= next_code;
      sink_drive <= next_drive;
    end
  end

  // ---------------------------------------------------------------
  // Read back
  // ---------------------------------------------------------------
  logic [7:0] next_rdata;

  always_comb
  begin
    next_rdata = 8'h00;
    case (reg_addr)
      ADDR_MODE:
      begin
        next_rdata[BIT_BACKLIGHT_ON] = backlight_on;
        next_rdata[BIT_DIM_REQUEST]  = dim_request;
        next_rdata[BIT_OPERATE]      = operate_not_standby;
      end
      ADDR_CONFIG:
      begin
        next_rdata[BIT_AUTO_ADJUST]  = auto_adjust;
        next_rdata[BIT_KEY_WAKE]     = key_wake_light;
        next_rdata[POS_CURVE +: 2]   = brightness_curve_select;
        next_rdata[POS_LEVEL +: 2]   = ambient_level_select;
      end
      ADDR_DELAYS:
      begin
        next_rdata[POS_DIM_DELAY +: 4] = dim_delay_setting;
        next_rdata[POS_OFF_DELAY +: 4] = off_delay_setting;
      end
      ADDR_L1_MAX: next_rdata = {1'b0, level_code[0]};
      ADDR_L1_LOW: next_rdata = {1'b0, level_code[1]};
      ADDR_L2_MAX: next_rdata = {1'b0, level_code[2]};
      ADDR_L2_LOW: next_rdata = {1'b0, level_code[3]};
      ADDR_L3_MAX: next_rdata = {1'b0, level_code[4]};
      ADDR_L3_LOW: next_rdata = {1'b0, level_code[5]};
      default:     next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      reg_rdata <= 8'h00;
    else if (reg_read)
      reg_rdata <= next_rdata;
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  sequence s_reassert;
    bl_reassert && reg_wdata[BIT_OPERATE] && !wdata_dim;
  endsequence

  sequence s_max_shown;
    !dim_request ##1 (sink_code == $past(sel_max));
  endsequence

  a_dark_off_now: assert property (@(posedge clock) disable iff (rst)
    !backlight_lit |=> (sink_code == 7'h00) && (sink_drive == 14'h0000))
    else $error("Backlight not dark one cycle after it went off.");

  a_max_code_out: assert property (@(posedge clock) disable iff (rst)
    (backlight_lit && !dim_request) |=> (sink_code == $past(sel_max)))
    else $error("Lit output did not carry the level max code.");

  a_dim_code_out: assert property (@(posedge clock) disable iff (rst)
    (backlight_lit && dim_request) |=> (sink_code == $past(sel_low)))
    else $error("Dimmed output did not carry the level dim code.");

  a_level_dark: assert property (@(posedge clock) disable iff (rst)
    (ambient_level_select[1] && backlight_lit && !dim_request) |=> (sink_code == $past(level_code[4])))
    else $error("Dark level did not select the third code pair.");

  a_linear_law: assert property (@(posedge clock) disable iff (rst)
    (brightness_curve_select == CURVE_LINEAR) |=> (sink_drive == 14'({7'h00, sink_code} * CODE_FULL)))
    else $error("Linear drive does not equal code times 127.");

  a_square_law: assert property (@(posedge clock) disable iff (rst)
    (brightness_curve_select == CURVE_SQUARE) |=> (sink_drive == 14'({7'h00, sink_code} * {7'h00, sink_code})))
    else $error("Square drive does not equal code squared.");

  a_key_wake_on: assert property (@(posedge clock) disable iff (rst)
    $rose(key_sync) && keypad_mode && key_wake_light |=> backlight_on)
    else $error("Key press did not set the on bit.");

  a_dim_expiry: assert property (@(posedge clock) disable iff (rst)
    (dim_expire && !restart_dim) |=> dim_request)
    else $error("Dim countdown expiry did not set the dim request.");

  a_host_dim_set: assert property (@(posedge clock) disable iff (rst)
    (wr_mode && wdata_dim && !key_wake) |=> dim_request)
    else $error("Host dim request write was not taken.");

  a_off_expiry: assert property (@(posedge clock) disable iff (rst)
    (off_expire && !wr_mode && !key_wake) |=> !backlight_on ##1 (sink_code == 7'h00))
    else $error("Off countdown expiry did not turn the backlight off.");

  a_reassert_max: assert property (@(posedge clock) disable iff (rst)
    s_reassert |=> s_max_shown)
    else $error("Re-asserting on did not restore the max code.");

  a_auto_level: assert property (@(posedge clock) disable iff (rst)
    auto_adjust |=> (ambient_level_select == $past(ambient_level_in)))
    else $error("Automatic mode did not follow the sensor level.");

  a_manual_level: assert property (@(posedge clock) disable iff (rst)
    (!auto_adjust && !wr_config) |=> $stable(ambient_level_select))
    else $error("Level field changed without a host write.");

endmodule : bld_backlight
`default_nettype wire

// *** test/bld_host_model.sv ***
// Host model that reaches the backlight registers over the parallel register port.
`timescale 1ns/10ps
`default_nettype none

module bld_host_model
(
  input  wire logic       clock,
  output var  logic [7:0] reg_addr,
  output var  logic [7:0] reg_wdata,
  output var  logic       reg_write,
  output var  logic       reg_read,
  input  wire logic [7:0] reg_rdata
);
  // ---------------------------------------------------------------
  // Bus cycles
  // ---------------------------------------------------------------
  // Strobes last one edge only, so the block never sees a doubled access.
  initial
  begin
    reg_addr  = 8'h00;
    reg_wdata = 8'h00;
    reg_write = 1'b0;
    reg_read  = 1'b0;
  end

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask : wr

  // Read data is registered on the strobe edge and held, so it is taken at the edge after.
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    @(posedge clock);
    d = reg_rdata;
  endtask : rd
endmodule : bld_host_model

`default_nettype wire

// *** test/bld_backlight_test.sv ***
// Self-checking testbench for the backlight level, dim and off control block.
`timescale 1ns/10ps
`default_nettype none

module bld_backlight_test
  import bld_pkg::*;
;
  logic        clock;
  logic        rst;
  logic        key_press_pin;
  logic        keypad_mode;
  logic [1:0]  ambient_level_in;
  wire  [7:0]  reg_addr;
  wire  [7:0]  reg_wdata;
  wire         reg_write;
  wire         reg_read;
  wire  [7:0]  reg_rdata;
  wire  [6:0]  sink_code;
  wire  [13:0] sink_drive;
  wire         backlight_lit;
  int          n_fail;
  int          comparisons;
  int          cyc = 0;
  int          i;
  int          n;
  int          k;
  logic [7:0]  d;
  logic [6:0]  e;
  logic [6:0]  mx [3];
  logic [6:0]  lo [3];

  bld_backlight #(.TICK_CYCLES(10)) dut_u
  (
    .clock(clock), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
    .reg_read(reg_read), .reg_rdata(reg_rdata), .key_press_pin(key_press_pin), .keypad_mode(keypad_mode),
    .ambient_level_in(ambient_level_in), .sink_code(sink_code), .sink_drive(sink_drive),
    .backlight_lit(backlight_lit)
  );

  bld_host_model host_u
  (
    .clock(clock), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
    .reg_read(reg_read), .reg_rdata(reg_rdata)
  );

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic settle();
    repeat (3) @(posedge clock);
    @(negedge clock);
  endtask : settle

  // One tick is ten cycles, so a setting of N seconds lands between N-1 and N ticks plus latency.
  task automatic wait_code(input logic [6:0] c, output int cnt);
    cnt = 0;
    do
    begin
      @(negedge clock);
      cnt++;
    end
    while (sink_code !== c && cnt < 400);
  endtask : wait_code

  task automatic conclude();
    if (n_fail == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : conclude

  initial
  begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  always @(posedge clock)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_fail++;
      conclude();
    end
  end

  // ---------------------------------------------------------------
  // Sequence
  // ---------------------------------------------------------------
  initial
  begin
    rst = 1'b1;
    key_press_pin = 1'b0;
    keypad_mode = 1'b0;
    ambient_level_in = 2'b00;
    n_fail = 0;
    comparisons = 0;
    mx = '{7'h40, 7'h55, 7'h33};
    lo = '{7'h10, 7'h22, 7'h66};
    repeat (10) @(posedge clock);
    rst <= 1'b0;
    for (i = 0; i < 11; i++)
    begin
      host_u.rd(8'(i), d);
      chk({8'h00, d}, 16'h0000);
    end
    chk({9'h000, sink_code}, 16'h0000);
    for (i = 0; i < 3; i++)
    begin
      host_u.wr(8'(ADDR_L1_MAX + 2 * i), {1'b1, mx[i]});
      host_u.wr(8'(ADDR_L1_LOW + 2 * i), {1'b0, lo[i]});
      host_u.rd(8'(ADDR_L1_MAX + 2 * i), d);
      chk({8'h00, d}, {9'h000, mx[i]});
    end
    host_u.wr(8'h04, 8'hFF);
    host_u.rd(8'h04, d);
    chk({8'h00, d}, 16'h0000);
    for (i = 0; i < 8; i++)
    begin
      host_u.wr(ADDR_CONFIG, 8'(((i >> 1) << 4) | ((i & 1) << 2) | ((i & 4) << 1)));
      host_u.wr(ADDR_MODE, 8'h21);
      settle();
      e = mx[((i >> 1) == 3) ? 2 : (i >> 1)];
      chk({9'h000, sink_code}, {9'h000, e});
      chk({2'b00, sink_drive}, (i & 5) ? 16'(e) * 16'(e) : 16'(e) * 16'd127);
    end
    repeat (300) @(posedge clock);
    @(negedge clock);
    chk({15'h0000, backlight_lit}, 16'h0001);
    host_u.wr(ADDR_CONFIG, 8'h00);
    host_u.wr(ADDR_MODE, 8'h01);
    settle();
    chk({15'h0000, backlight_lit}, 16'h0000);
    chk({9'h000, sink_code}, 16'h0000);
    host_u.wr(ADDR_DELAYS, 8'h21);
    host_u.wr(ADDR_MODE, 8'h21);
    wait_code(lo[0], n);
    chk({15'h0000, n >= 88 && n <= 106}, 16'h0001);
    host_u.rd(ADDR_MODE, d);
    chk({14'h0000, d[1:0]}, 16'h0003);
    wait_code(7'h00, k);
    chk({15'h0000, n + k >= 134 && n + k <= 158}, 16'h0001);
    host_u.rd(ADDR_MODE, d);
    chk({15'h0000, d[0] | backlight_lit}, 16'h0000);
    host_u.wr(ADDR_MODE, 8'h21);
    repeat (60) @(posedge clock);
    host_u.wr(ADDR_MODE, 8'h21);
    wait_code(lo[0], n);
    chk({15'h0000, n >= 88 && n <= 106}, 16'h0001);
    host_u.wr(ADDR_MODE, 8'h21);
    settle();
    chk({9'h000, sink_code}, {9'h000, mx[0]});
    wait_code(lo[0], n);
    chk({15'h0000, n >= 85 && n <= 106}, 16'h0001);
    host_u.wr(ADDR_MODE, 8'h20);
    @(posedge clock);
    @(negedge clock);
    chk({15'h0000, backlight_lit}, 16'h0000);
    settle();
    chk({9'h000, sink_code}, 16'h0000);
    host_u.wr(ADDR_DELAYS, 8'h00);
    host_u.wr(ADDR_CONFIG, 8'h02);
    for (i = 0; i < 2; i++)
    begin
      @(posedge clock);
      keypad_mode <= 1'(i);
      key_press_pin <= 1'b1;
      repeat (6) @(posedge clock);
      @(negedge clock);
      chk({15'h0000, backlight_lit}, 16'(i));
      @(posedge clock);
      key_press_pin <= 1'b0;
      settle();
    end
    chk({9'h000, sink_code}, {9'h000, mx[0]});
    @(posedge clock);
    ambient_level_in <= 2'b01;
    host_u.wr(ADDR_CONFIG, 8'h01);
    host_u.wr(ADDR_CONFIG, 8'h21);
    host_u.rd(ADDR_CONFIG, d);
    chk({8'h00, d}, 16'h0011);
    host_u.wr(ADDR_MODE, 8'h21);
    settle();
    chk({9'h000, sink_code}, {9'h000, mx[1]});
    @(posedge clock);
    ambient_level_in <= 2'b11;
    settle();
    chk({9'h000, sink_code}, {9'h000, mx[2]});
    host_u.wr(ADDR_MODE, 8'h23);
    settle();
    chk({9'h000, sink_code}, {9'h000, lo[2]});
    chk({2'b00, sink_drive}, 16'(lo[2]) * 16'd127);
    conclude();
  end
endmodule : bld_backlight_test

`default_nettype wire
